// ### hw/dhp_dev.sv
// Device end of the downconverter processor port
`timescale 1ns/1ps
module dhp_dev (
  input  wire logic                                       CLK,
  input  wire logic                                       SYS_RST,
  input  wire logic                                       NEW_DATA,
  output logic [dhp_pkg::LOC_N-1:0][dhp_pkg::DATA_W-1:0]  TARGET_REGS,
  dhp_if.dev                                              bus
);
  import dhp_pkg::*;

  logic                         strobe_q;
  logic                         strobe_d;
  logic [LOC_N-1:0][DATA_W-1:0] loc_q;
  logic [DATA_W-1:0]            rd_data_q;
  logic [DATA_W-1:0]            rd_data_d;
  logic [IRQ_LEN_W-1:0]         irq_cnt_q;
  logic [IRQ_LEN_W-1:0]         irq_cnt_d;
  logic                         irq_q;
  logic                         irq_d;
  logic                         selected;
  logic                         strobe_rise;
  logic                         write_evt;
  logic                         read_drive;
  logic [LOC_W-1:0]             loc_sel;
  logic                         halted;
  logic [LOC_N-1:0]             loc_hit;
  logic [LOC_N-1:0]             loc_wr;
  logic [IRQ_LEN_W-1:0]         irq_len;
  logic                         irq_load;
  logic                         irq_run;
  logic                         split_wr;
  logic                         split_rd;
  logic                         dir_wr;
  logic                         dir_rd;

  // Only the two low index lines decode
  assign loc_sel     = bus.host_index_lines[LOC_W-1:0];
  assign selected    = ~bus.chip_select_n;
  assign strobe_rise = bus.transfer_pulse & ~strobe_q;
  assign halted      = ~bus.reset_n;

  // Split style: separate write and read strobes
  assign split_wr = strobe_rise & selected;
  assign split_rd = selected & ~bus.fetch_pulse;
  // Direction style: fetch line low writes, high reads
  assign dir_wr   = strobe_rise & selected & ~bus.fetch_pulse;
  assign dir_rd   = selected & bus.fetch_pulse & ~bus.transfer_pulse;

  // Unknown or floating style pin falls to split style
  always_comb begin
    case (bus.host_style_select)
      STYLE_DIR: begin
        write_evt  = dir_wr;
        read_drive = dir_rd;
      end
      default: begin
        write_evt  = split_wr;
        read_drive = split_rd;
      end
    endcase
  end

  // Data from a flop: first read cycle shows last cycle's location
  assign bus.dev_data_o   = rd_data_q;
  assign bus.dev_data_oe  = read_drive;
  assign bus.new_data_irq = irq_q;
  assign TARGET_REGS      = loc_q;

  // Strobe history idles high so release gives no false rise
  always_comb begin
    strobe_d = bus.transfer_pulse;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= strobe_d;
    end
  end

  // One decoder and one register per location
  for (genvar g = 0; g < LOC_N; g++) begin : gen_loc
    logic [DATA_W-1:0] word_q;
    logic [DATA_W-1:0] word_d;

    assign loc_hit[g] = (loc_sel == LOC_W'(g));
    assign loc_wr[g]  = loc_hit[g] & write_evt;
    assign loc_q[g]   = word_q;

    always_comb begin
      word_d = word_q;
      if (halted) begin
        if (g == LOC_IRQLEN) begin
          word_d = IRQLEN_RST;
        end else if (g == LOC_HOLD) begin
          word_d = HOLD_RST;
        end else begin
          word_d = TGT_RST;
        end
      end else if (loc_wr[g]) begin
        // Holding takes the bus; the others copy holding
        if (g == LOC_HOLD) begin
          word_d = bus.host_data_bus;
        end else begin
          word_d = loc_q[LOC_HOLD];
        end
      end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        word_q <= TGT_RST;
      end else begin
        word_q <= word_d;
      end
    end
  end

  // Registered read word: host must hold the index two cycles
  always_comb begin
    rd_data_d = loc_q[loc_sel];
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_data_q <= TGT_RST;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // Halt stops a running pulse and blocks new starts
  assign irq_len  = loc_q[LOC_IRQLEN][IRQ_LEN_W-1:0];
  assign irq_load = ~halted & NEW_DATA;
  assign irq_run  = ~halted & (irq_cnt_q > CNT_ONE);

  // New data restarts the pulse; a zero length gives none
  always_comb begin
    irq_cnt_d = CNT_ZERO;
    irq_d     = 1'b0;
    if (irq_load) begin
      irq_cnt_d = irq_len;
      irq_d     = (irq_len != CNT_ZERO);
    end else if (irq_run) begin
      irq_cnt_d = irq_cnt_q - CNT_ONE;
      irq_d     = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_cnt_q <= CNT_ZERO;
      irq_q     <= 1'b0;
    end else begin
      irq_cnt_q <= irq_cnt_d;
      irq_q     <= irq_d;
    end
  end
endmodule : dhp_dev

// ### hw/dhp_pkg.sv
// Shared constants and types for the host port and its partner
package dhp_pkg;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned INDEX_W    = 3;
  localparam int unsigned LOC_W      = 2;
  localparam int unsigned LOC_N      = 4;
  localparam int unsigned IRQ_LEN_W  = 8;
  localparam logic [1:0]  LOC_HOLD   = 2'h0;
  localparam logic [1:0]  LOC_IRQLEN = 2'h3;
  localparam logic [15:0] HOLD_RST   = 16'h0000;
  localparam logic [15:0] TGT_RST    = 16'h0000;
  localparam logic [15:0] IRQLEN_RST = 16'h0001;
  localparam logic [15:0] BUS_IDLE   = 16'hFFFF;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  localparam logic [7:0]  CNT_ONE    = 8'h01;
  localparam logic [3:0]  STROBE_CYC = 4'h3;
  localparam logic [3:0]  HOLD_CYC   = 4'h1;
  localparam logic        STYLE_SPLIT = 1'b0;
  localparam logic        STYLE_DIR   = 1'b1;

  typedef enum logic [2:0] {
    DHP_IDLE   = 3'b000,
    DHP_SETUP  = 3'b001,
    DHP_STROBE = 3'b010,
    DHP_HOLD   = 3'b011,
    DHP_DONE   = 3'b100
  } dhp_state_t;
endpackage : dhp_pkg

// ### hw/dhp_if.sv
// Pin-level link between the processor and the downconverter port
`timescale 1ns/1ps
interface dhp_if;
  import dhp_pkg::*;
  logic [DATA_W-1:0]  host_data_o;
  logic               host_data_oe;
  logic [DATA_W-1:0]  dev_data_o;
  logic               dev_data_oe;
  logic [DATA_W-1:0]  host_data_bus;
  logic [INDEX_W-1:0] host_index_lines;
  logic               chip_select_n;
  logic               transfer_pulse;
  logic               fetch_pulse;
  logic               host_style_select;
  logic               reset_n;
  logic               new_data_irq;

  // Wire level from the enables; idle bus floats high
  assign host_data_bus = dev_data_oe  ? dev_data_o :
                         host_data_oe ? host_data_o : BUS_IDLE;

  modport dev (
    input  host_data_bus, host_index_lines, chip_select_n, transfer_pulse,
    input  fetch_pulse, host_style_select, reset_n,
    output dev_data_o, dev_data_oe, new_data_irq
  );
  modport host (
    input  host_data_bus, new_data_irq,
    output host_data_o, host_data_oe, host_index_lines, chip_select_n,
    output transfer_pulse, fetch_pulse, host_style_select, reset_n
  );
endinterface : dhp_if

// ### hw/dhp_host.sv
// Processor end: turns simple requests into strobed pin cycles
`timescale 1ns/1ps
module dhp_host (
  input  wire logic                           CLK,
  input  wire logic                           SYS_RST,
  input  wire logic                           STYLE,
  input  wire logic                           DEV_RESET_N,
  input  wire logic                           REQ,
  input  wire logic                           REQ_WRITE,
  input  wire logic [dhp_pkg::INDEX_W-1:0]    REQ_INDEX,
  input  wire logic [dhp_pkg::DATA_W-1:0]     REQ_DATA,
  output logic                                READY,
  output logic                                DONE,
  output logic [dhp_pkg::DATA_W-1:0]          RD_DATA,
  output logic                                IRQ,
  dhp_if.host                                 bus
);
  import dhp_pkg::*;

  dhp_state_t          state_q,  state_d;
  logic [3:0]          cnt_q,    cnt_d;
  logic                write_q,  write_d;
  logic [INDEX_W-1:0]  index_q,  index_d;
  logic [DATA_W-1:0]   wdata_q,  wdata_d;
  logic [DATA_W-1:0]   rdata_q,  rdata_d;
  logic                active;
  logic                strobe_low;

  assign active     = (state_q != DHP_IDLE) && (state_q != DHP_DONE);
  assign strobe_low = (state_q == DHP_STROBE);
  assign READY      = (state_q == DHP_IDLE);
  assign DONE       = (state_q == DHP_DONE);
  assign RD_DATA    = rdata_q;
  assign IRQ        = bus.new_data_irq;

  // Select and index stay steady over the whole access
  assign bus.chip_select_n     = ~active;
  assign bus.host_index_lines  = index_q;
  assign bus.host_style_select = STYLE;
  assign bus.reset_n           = DEV_RESET_N;
  assign bus.host_data_o       = wdata_q;
  // Host drives only for writes, never during a read
  assign bus.host_data_oe      = active & write_q;

  always_comb begin
    if (STYLE == STYLE_DIR) begin
      bus.transfer_pulse = ~strobe_low;
      bus.fetch_pulse    = active ? ~write_q : 1'b1;
    end else begin
      bus.transfer_pulse = ~(strobe_low & write_q);
      bus.fetch_pulse    = ~(strobe_low & ~write_q);
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    write_d = write_q;
    index_d = index_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    case (state_q)
      DHP_IDLE: begin
        if (REQ) begin
          write_d = REQ_WRITE;
          index_d = REQ_INDEX;
          wdata_d = REQ_DATA;
          state_d = DHP_SETUP;
        end
      end
      DHP_SETUP: begin
        cnt_d   = STROBE_CYC;
        state_d = DHP_STROBE;
      end
      DHP_STROBE: begin
        // Sample late in the strobe so the device flop has settled
        if (cnt_q == HOLD_CYC) begin
          if (!write_q) begin
            rdata_d = bus.host_data_bus;
          end
          state_d = DHP_HOLD;
        end else begin
          cnt_d = cnt_q - HOLD_CYC;
        end
      end
      DHP_HOLD: begin
        state_d = DHP_DONE;
      end
      DHP_DONE: begin
        state_d = DHP_IDLE;
      end
      default: begin
        state_d = DHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= DHP_IDLE;
      cnt_q   <= 4'h0;
      write_q <= 1'b0;
      index_q <= 3'h0;
      wdata_q <= HOLD_RST;
      rdata_q <= HOLD_RST;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      write_q <= write_d;
      index_q <= index_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end
endmodule : dhp_host

// ### sim/dhp_asserts.sv
// Pin-level checks on the processor port link
`timescale 1ns/1ps
module dhp_asserts (
  input wire logic                       CLK,
  input wire logic                       SYS_RST,
  input wire logic [dhp_pkg::DATA_W-1:0] host_data_bus,
  input wire logic [dhp_pkg::DATA_W-1:0] dev_data_o,
  input wire logic                       dev_data_oe,
  input wire logic [dhp_pkg::INDEX_W-1:0] host_index_lines,
  input wire logic                       chip_select_n,
  input wire logic                       transfer_pulse,
  input wire logic                       fetch_pulse,
  input wire logic                       host_style_select,
  input wire logic                       reset_n,
  input wire logic                       new_data_irq
);
  import dhp_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Host strobe: three low cycles, then the rise
  sequence strobe_low;
    !transfer_pulse [*3] ##1 transfer_pulse;
  endsequence
  a_split_read: assert property (
    !host_style_select && !chip_select_n && !fetch_pulse |-> dev_data_oe)
    else $error("split read not driven");
  a_dir_read: assert property (
    host_style_select && !chip_select_n && fetch_pulse && !transfer_pulse |-> dev_data_oe)
    else $error("direction read not driven");
  a_bus_free: assert property (
    dev_data_oe |-> !chip_select_n &&
    (host_style_select ? fetch_pulse && !transfer_pulse : !fetch_pulse))
    else $error("bus driven outside read");
  a_bus_value: assert property (
    dev_data_oe |-> host_data_bus == dev_data_o) else $error("bus level wrong");
  a_strobe_shape: assert property (
    $fell(transfer_pulse) |-> strobe_low) else $error("strobe shape wrong");
  a_cs_strobe: assert property (
    !transfer_pulse |-> !chip_select_n) else $error("strobe without select");
  a_index_hold: assert property (
    !chip_select_n && $past(!chip_select_n) |-> $stable(host_index_lines))
    else $error("index moved in cycle");
  a_irq_reset: assert property (
    !reset_n |=> !new_data_irq) else $error("irq during reset");
endmodule : dhp_asserts

// ### sim/dhp_bench.sv
// Bench joining host and device ends of the processor port
`timescale 1ns/1ps
module downconverter_host_port_bench;
  import dhp_pkg::*;
  logic                             clk = 1'b0, sys_rst = 1'b1, style = 1'b0;
  logic                             dev_rst_n = 1'b1, req = 1'b0, req_wr = 1'b0;
  logic                             new_data = 1'b0, ready, done, irq;
  logic [INDEX_W-1:0]               req_idx = 3'h0;
  logic [DATA_W-1:0]                req_dat = 16'h0000, rd_data;
  logic [LOC_N-1:0][DATA_W-1:0]     tgt;
  int                               mismatches = 0, total_checks = 0;
  always #2 clk = ~clk;
  dhp_if pins ();
  dhp_dev dhp_dev_inst (.CLK(clk), .SYS_RST(sys_rst), .NEW_DATA(new_data),
    .TARGET_REGS(tgt), .bus(pins.dev));
  dhp_host dhp_host_inst (.CLK(clk), .SYS_RST(sys_rst), .STYLE(style),
    .DEV_RESET_N(dev_rst_n), .REQ(req), .REQ_WRITE(req_wr), .REQ_INDEX(req_idx),
    .REQ_DATA(req_dat), .READY(ready), .DONE(done), .RD_DATA(rd_data), .IRQ(irq),
    .bus(pins.host));
  dhp_asserts dhp_asserts_inst (.CLK(clk), .SYS_RST(sys_rst),
    .host_data_bus(pins.host_data_bus), .dev_data_o(pins.dev_data_o),
    .dev_data_oe(pins.dev_data_oe), .host_index_lines(pins.host_index_lines),
    .chip_select_n(pins.chip_select_n), .transfer_pulse(pins.transfer_pulse),
    .fetch_pulse(pins.fetch_pulse), .host_style_select(pins.host_style_select),
    .reset_n(pins.reset_n), .new_data_irq(pins.new_data_irq));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One host request; read data taken in the done cycle
  task automatic xfer(input logic w, input logic [2:0] i, input logic [15:0] d,
                      output logic [15:0] r);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    {req, req_wr, req_idx, req_dat} = {1'b1, w, i, d};
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    r = rd_data;
    chk("done", 16'h0001, {15'h0000, done});
    // Commit lands a cycle after the strobe rise
    repeat (2) @(negedge clk);
  endtask : xfer
  initial begin
    logic [15:0] v, r, cnt;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    for (int k = 0; k < LOC_N; k++) chk("rst", TGT_RST, tgt[k]);
    for (int s = 0; s < 2; s++) begin
      style = s[0];
      v = s[0] ? 16'h8001 : 16'hA5C3;
      xfer(1'b1, 3'h0, v, r);
      xfer(1'b1, 3'h1, ~v, r);
      chk("tgt1", v, tgt[1]);
      xfer(1'b0, 3'h5, 16'h0000, r);
      chk("rd1", v, r);
      xfer(1'b1, 3'h4, ~v, r);
      xfer(1'b1, 3'h6, v, r);
      chk("tgt2", ~v, tgt[2]);
      chk("idle", BUS_IDLE, pins.host_data_bus);
    end
    xfer(1'b1, 3'h0, 16'h0003, r);
    xfer(1'b1, 3'h3, 16'h0000, r);
    new_data = 1'b1;
    @(negedge clk);
    new_data = 1'b0;
    cnt = 16'h0000;
    // Pulse is already up here, so look before each wait
    repeat (8) begin
      if (irq === 1'b1) cnt++;
      @(negedge clk);
    end
    chk("irq", 16'h0003, cnt);
    dev_rst_n = 1'b0;
    // Write while held in reset must be dropped
    xfer(1'b1, 3'h0, 16'h1234, r);
    dev_rst_n = 1'b1;
    chk("rl3", IRQLEN_RST, tgt[3]);
    chk("rl1", TGT_RST, tgt[1]);
    chk("rl0", HOLD_RST, tgt[0]);
    give_verdict();
  end
  initial begin
    repeat (4000) @(posedge clk);
    $display("FAIL watchdog expected finish seen timeout");
    mismatches++;
    give_verdict();
  end
endmodule : downconverter_host_port_bench
